/* src/dftc_params.svh */
// Register offsets, reset values and timing counts of the adaptive fan-start control bank.
`ifndef DFTC_PARAMS_SVH
`define DFTC_PARAMS_SVH
`define DFTC_OFS_CPU_PT      8'h8A
`define DFTC_OFS_R1_PT       8'h8B
`define DFTC_OFS_LOC_PT      8'h8C
`define DFTC_OFS_R2_PT       8'h8D
`define DFTC_OFS_CTRL        8'h8E
`define DFTC_RST_CPU_PT      8'hFB
`define DFTC_RST_TEMP_PT     8'h64
`define DFTC_RST_CTRL        8'h00
`define DFTC_BIT_R2_IVL_MSB  0
`define DFTC_BIT_SUPPLY_GRD  1
`define DFTC_BIT_R1_COPY     2
`define DFTC_BIT_LOC_COPY    3
`define DFTC_BIT_R2_COPY     4
`define DFTC_BIT_R1_EN       5
`define DFTC_BIT_LOC_EN      6
`define DFTC_BIT_R2_EN       7
`define DFTC_DEC_BASE_CYC    12'h008
`endif

/* src/dftc_pkg.sv */
// Types shared by the adaptive fan-start control bank.
package dftc_pkg;
    typedef logic [7:0]  dftc_byte_t;
    typedef logic [11:0] dftc_cycles_t;
    // Copy sequencer states, one-hot.
    typedef enum logic [1:0] {
        DFTC_IDLE = 2'b01,
        DFTC_HELD = 2'b10
    } dftc_ot_state_t;
endpackage

/* src/dftc_bank.sv */
// Adaptive fan-start control register bank with overtemperature copy and supply guard.
//==============================================================
// Operation
// R1: Hold one target point per temperature channel.
// R2: Adaptive control regulates channel around target point.
// R3: Lock makes all five registers read-only.
// R4: Reset targets: CPU 0xFB, others 0x64.
// R5: Control register resets to zero.
// R6: Control bit 0 is remote2 interval MSB.
// R7: Guarded low core voltage sets status, alert.
// R8: Guarded low voltage disables hot, adaptive, shutdown.
// R9: Remote1 copy option loads remote1 temperature.
// R10: Local copy option loads local temperature.
// R11: Remote2 copy option loads remote2 temperature.
// R12: Enable bit makes channel adapt start temperature.
// R13: Cleared enable leaves start temperature unchanged.
// R14: Interval code gives decrease 8<<code, increase double.
// R15: Copy once per overtemp assertion edge.
// R16: Overtemp copy ignores the lock.
`timescale 1ns/1ns
`include "dftc_params.svh"
module dftc_bank (
    input  wire logic                core_clk_i,       // Device clock, 250 MHz.
    input  wire logic                rst_b_i,          // Synchronous reset, active low.
    input  wire logic                reg_wr_i,         // Register write strobe.
    input  wire logic [7:0]          reg_addr_i,       // Register address.
    input  wire dftc_pkg::dftc_byte_t reg_wdata_i,     // Write data.
    output logic      [7:0]          reg_rdata_o,      // Read data, registered.
    input  wire logic                cfg_lock_i,       // Configuration lock bit.
    input  wire logic [1:0]          r2_ivl_low_i,     // Low two bits of remote2 interval.
    input  wire logic                overtemp_input_i, // Overtemperature input, active high.
    input  wire dftc_pkg::dftc_byte_t r1_temp_i,       // Present remote1 temperature.
    input  wire dftc_pkg::dftc_byte_t loc_temp_i,      // Present local temperature.
    input  wire dftc_pkg::dftc_byte_t r2_temp_i,       // Present remote2 temperature.
    input  wire logic                standby_supply_i, // Device runs from standby supply.
    input  wire logic                core_voltage_low_i, // Core voltage below its low limit.
    output logic [7:0]               cpu_pt_o,         // CPU interface target point.
    output logic [7:0]               r1_pt_o,          // Remote1 target point.
    output logic [7:0]               loc_pt_o,         // Local target point.
    output logic [7:0]               r2_pt_o,          // Remote2 target point.
    output logic [2:0]               adapt_run_o,      // Adaptive run per channel: r1, local, r2.
    output logic                     core_low_status_o, // Status bit for guarded low core voltage.
    output logic                     alert_req_o,      // Alert request for guarded low core voltage.
    output logic                     hot_monitor_en_o, // Processor-hot monitoring allowed.
    output logic                     shutdown_block_o, // Shutdown entry blocked.
    output logic [11:0]              r2_dec_cycles_o,  // Remote2 decrease interval in monitoring cycles.
    output logic [11:0]              r2_inc_cycles_o   // Remote2 increase interval in monitoring cycles.
);
    import dftc_pkg::*;

    //==============================================================
    // Storage
    dftc_byte_t     pt_r [4];        // Target points: cpu, r1, local, r2.
    dftc_byte_t     ctrl_r;          // Adaptive control register.
    dftc_ot_state_t ot_r;            // Overtemp edge sequencer.
    dftc_ot_state_t ot_nxt;          // Next sequencer state.
    logic           guard_r;         // Registered guarded low-voltage condition.

    // Returns the decrease interval for a three-bit code.
    function automatic dftc_cycles_t dec_cycles(input logic [2:0] code);
        dec_cycles = `DFTC_DEC_BASE_CYC << code;
    endfunction

    //==============================================================
    // Decode
    wire       wr_ok   = reg_wr_i & ~cfg_lock_i;                 // see R3
    wire       ctrl_we = wr_ok & (reg_addr_i == `DFTC_OFS_CTRL);
    wire       ot_edge = overtemp_input_i & (ot_r == DFTC_IDLE); // see R15
    wire [3:0] pt_we;                                            // Host write per target point.
    wire [3:0] pt_cp;                                            // Overtemp copy per target point.
    wire [7:0] cp_src [4];                                       // Copy source per target point.
    wire       guard_now = ctrl_r[`DFTC_BIT_SUPPLY_GRD] & standby_supply_i & core_voltage_low_i; // see R7
    wire [2:0] r2_code = {ctrl_r[`DFTC_BIT_R2_IVL_MSB], r2_ivl_low_i}; // see R6

    assign cp_src[0] = 8'h00;
    assign cp_src[1] = r1_temp_i;
    assign cp_src[2] = loc_temp_i;
    assign cp_src[3] = r2_temp_i;
    assign pt_cp[0]  = 1'b0;
    assign pt_cp[1]  = ot_edge & ctrl_r[`DFTC_BIT_R1_COPY];  // see R9 R16
    assign pt_cp[2]  = ot_edge & ctrl_r[`DFTC_BIT_LOC_COPY]; // see R10 R16
    assign pt_cp[3]  = ot_edge & ctrl_r[`DFTC_BIT_R2_COPY];  // see R11 R16

    //==============================================================
    // Target point registers; a copy wins over a host write in the same cycle.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pt
            assign pt_we[g] = wr_ok & (reg_addr_i == (`DFTC_OFS_CPU_PT + 8'(g)));
            // Stores one target point.
            always_ff @(posedge core_clk_i) begin
                if (!rst_b_i) begin
                    pt_r[g] <= (g == 0) ? `DFTC_RST_CPU_PT : `DFTC_RST_TEMP_PT; // see R4
                end else if (pt_cp[g]) begin
                    pt_r[g] <= cp_src[g];
                end else if (pt_we[g]) begin
                    pt_r[g] <= reg_wdata_i; // see R1
                end
            end
        end
    endgenerate

    // Control register.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ctrl_r <= `DFTC_RST_CTRL; // see R5
        end else if (ctrl_we) begin
            ctrl_r <= reg_wdata_i;
        end
    end

    // Sequencer: one copy per rising edge of the overtemp input.
    always_comb begin
        case (ot_r)
            DFTC_IDLE: ot_nxt = overtemp_input_i ? DFTC_HELD : DFTC_IDLE;
            DFTC_HELD: ot_nxt = overtemp_input_i ? DFTC_HELD : DFTC_IDLE;
            default:   ot_nxt = DFTC_IDLE;
        endcase
    end

    // Sequencer state and guard register.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ot_r    <= DFTC_IDLE;
            guard_r <= 1'b0;
        end else begin
            ot_r    <= ot_nxt;
            guard_r <= guard_now;
        end
    end

    //==============================================================
    // Read path, registered.
    wire [7:0] rd_sel = (reg_addr_i == `DFTC_OFS_CTRL) ? ctrl_r :
                        (reg_addr_i >= `DFTC_OFS_CPU_PT && reg_addr_i <= `DFTC_OFS_R2_PT) ?
                        pt_r[2'(reg_addr_i - `DFTC_OFS_CPU_PT)] : 8'h00;
    // Captures read data every cycle.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rd_sel;
        end
    end

    //==============================================================
    // Outputs.
    assign cpu_pt_o          = pt_r[0];
    assign r1_pt_o           = pt_r[1];
    assign loc_pt_o          = pt_r[2];
    assign r2_pt_o           = pt_r[3];
    // Each enable lets its channel adapt, unless the guard holds; R2 regulation is downstream.
    assign adapt_run_o       = {ctrl_r[`DFTC_BIT_R2_EN], ctrl_r[`DFTC_BIT_LOC_EN],
                                ctrl_r[`DFTC_BIT_R1_EN]} & {3{~guard_r}}; // see R2 R12 R13 R8
    assign core_low_status_o = guard_r;  // see R7
    assign alert_req_o       = guard_r;  // see R7
    assign hot_monitor_en_o  = ~guard_r; // see R8
    assign shutdown_block_o  = guard_r;  // see R8
    assign r2_dec_cycles_o   = dec_cycles(r2_code);        // see R14
    assign r2_inc_cycles_o   = dec_cycles(r2_code) << 1;   // see R14

    //==============================================================
    // Checks.
    property p_lock_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && cfg_lock_i && reg_addr_i == `DFTC_OFS_CTRL) |=> $stable(ctrl_r);
    endproperty
    a_lock_write: assert property (p_lock_write) else $error("Locked write changed control."); // see R3
    property p_ctrl_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && !cfg_lock_i && reg_addr_i == `DFTC_OFS_CTRL) |=> ctrl_r == $past(reg_wdata_i);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("Control write lost."); // see R3
    property p_r1_copy;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (overtemp_input_i && ot_r == DFTC_IDLE && ctrl_r[`DFTC_BIT_R1_COPY]) |=> r1_pt_o == $past(r1_temp_i);
    endproperty
    a_r1_copy: assert property (p_r1_copy) else $error("Remote1 copy missing."); // see R9
    property p_loc_copy;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (overtemp_input_i && ot_r == DFTC_IDLE && ctrl_r[`DFTC_BIT_LOC_COPY]) |=> loc_pt_o == $past(loc_temp_i);
    endproperty
    a_loc_copy: assert property (p_loc_copy) else $error("Local copy missing."); // see R10
    property p_r2_nocopy;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!ctrl_r[`DFTC_BIT_R2_COPY] && !reg_wr_i) |=> $stable(r2_pt_o);
    endproperty
    a_r2_nocopy: assert property (p_r2_nocopy) else $error("Remote2 point changed."); // see R11
    property p_once;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (overtemp_input_i && !reg_wr_i) ##1 (overtemp_input_i && !reg_wr_i) |=> $stable(r1_pt_o);
    endproperty
    a_once: assert property (p_once) else $error("Copy repeated while held."); // see R15
    property p_guard;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        guard_now |=> (adapt_run_o == 3'h0 && !hot_monitor_en_o && shutdown_block_o && alert_req_o);
    endproperty
    a_guard: assert property (p_guard) else $error("Guard effects missing."); // see R8
    property p_interval;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        r2_inc_cycles_o == {r2_dec_cycles_o[10:0], 1'b0} && r2_dec_cycles_o >= 12'h008;
    endproperty
    a_interval: assert property (p_interval) else $error("Interval decode wrong."); // see R14
    // The reset edge leaves every target point, the control register and the guard at their power-on values.
    property p_reset_vals;
        @(posedge core_clk_i) !rst_b_i |=> (cpu_pt_o == `DFTC_RST_CPU_PT && r1_pt_o == `DFTC_RST_TEMP_PT &&
            loc_pt_o == `DFTC_RST_TEMP_PT && r2_pt_o == `DFTC_RST_TEMP_PT && ctrl_r == `DFTC_RST_CTRL && !guard_r);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("Reset value wrong."); // see R4 R5
    // A locked host write leaves every target point alone unless a copy lands.
    property p_lock_point;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && cfg_lock_i && !ot_edge) |=>
            ($stable(cpu_pt_o) && $stable(r1_pt_o) && $stable(loc_pt_o) && $stable(r2_pt_o));
    endproperty
    a_lock_point: assert property (p_lock_point) else $error("Locked write changed a target point."); // see R3
    // Remote2 copy takes the temperature present at the edge.
    property p_r2_copy;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (overtemp_input_i && ot_r == DFTC_IDLE && ctrl_r[`DFTC_BIT_R2_COPY]) |=> r2_pt_o == $past(r2_temp_i);
    endproperty
    a_r2_copy: assert property (p_r2_copy) else $error("Remote2 copy missing."); // see R11
    // Once the guarded condition clears, status, alert, hot monitoring and shutdown are released.
    property p_guard_release;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !guard_now |=> (hot_monitor_en_o && !shutdown_block_o && !core_low_status_o && !alert_req_o);
    endproperty
    a_guard_release: assert property (p_guard_release) else $error("Guard effects not released."); // see R8
    c_copy:   cover property (@(posedge core_clk_i) pt_cp[1]);
    c_held:   cover property (@(posedge core_clk_i) ot_r == DFTC_HELD && overtemp_input_i);
    c_locked: cover property (@(posedge core_clk_i) reg_wr_i && cfg_lock_i);
    c_guard:  cover property (@(posedge core_clk_i) guard_r);
endmodule

/* verification/dftc_bank_tb_top.sv */
// Self-checking testbench for the adaptive fan-start control register bank.
`timescale 1ns/1ns
`include "dftc_params.svh"
module dftc_bank_tb_top;
    import dftc_pkg::*;
    // A note: which output to look at and the value it must show.
    typedef struct { int sel; logic [11:0] exp; } dftc_note_t;
    //==============================================================
    // Signals
    logic        clk, rst_b, reg_wr, lock, ot, stby, vlow;   // Clock, reset and control inputs.
    logic [7:0]  reg_addr, reg_wdata, rdata;                 // Register access.
    logic [7:0]  t1, tl, t2, cpu_pt, r1_pt, loc_pt, r2_pt;   // Temperatures and target points.
    logic [7:0]  d [5];                                      // Values written to the five registers.
    logic [1:0]  ivl_low;                                    // Low interval bits.
    logic [2:0]  run;                                        // Adaptive run per channel.
    logic        st, al, hot, sd;                            // Guard outputs.
    logic [11:0] dec, inc;                                   // Interval outputs.
    int          bad_count, n_checks, i;                     // Counters and loop index.
    integer      seed;                                       // Random seed.
    dftc_note_t  notes [$];                                  // Expected results, oldest first.
    string       nm [9] = '{"rdata", "r1_pt", "loc_pt", "r2_pt", "cpu_pt", "adapt_run", "guard", "dec", "inc"};
    dftc_bank u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata), .cfg_lock_i(lock), .r2_ivl_low_i(ivl_low),
        .overtemp_input_i(ot), .r1_temp_i(t1), .loc_temp_i(tl), .r2_temp_i(t2), .standby_supply_i(stby),
        .core_voltage_low_i(vlow), .cpu_pt_o(cpu_pt), .r1_pt_o(r1_pt), .loc_pt_o(loc_pt), .r2_pt_o(r2_pt),
        .adapt_run_o(run), .core_low_status_o(st), .alert_req_o(al), .hot_monitor_en_o(hot),
        .shutdown_block_o(sd), .r2_dec_cycles_o(dec), .r2_inc_cycles_o(inc));
    //==============================================================
    // Clock, and a watchdog that cuts a hang short.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
    // Picks the output that a note refers to.
    function automatic logic [11:0] view(input int s);
        case (s)
            0: return {4'h0, rdata};
            1: return {4'h0, r1_pt};
            2: return {4'h0, loc_pt};
            3: return {4'h0, r2_pt};
            4: return {4'h0, cpu_pt};
            5: return {9'h000, run};
            6: return {8'h00, st, al, hot, sd};
            7: return dec;
            default: return inc;
        endcase
    endfunction
    // Monitor: at mid-cycle, when outputs have settled, compares every pending note.
    always @(negedge clk) begin
        while (notes.size() > 0) begin
            n_checks++;
            if (view(notes[0].sel) !== notes[0].exp) begin
                bad_count++;
                $display("[FAIL] %s expected %h seen %h", nm[notes[0].sel], notes[0].exp, view(notes[0].sel));
            end
            void'(notes.pop_front());
        end
    end
    //==============================================================
    // Driver tasks; every input changes by non-blocking assignment at a rising edge.
    task automatic chk(input int s, input logic [11:0] e);
        notes.push_back('{s, e});
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        reg_addr <= a;
        tick(1);
        chk(0, {4'h0, e});
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    //==============================================================
    // Main sequence.
    initial begin
        seed = 32'hE82E2479;
        {rst_b, reg_wr, lock, ot, stby, vlow, ivl_low} = '0;
        {reg_addr, reg_wdata, t1, tl, t2} = '0;
        tick(2);
        rst_b <= 1'b1;
        // Reset values, then unmapped places read as zero.
        rd(`DFTC_OFS_CPU_PT, `DFTC_RST_CPU_PT);
        for (i = 1; i < 4; i++) rd(`DFTC_OFS_CPU_PT + 8'(i), `DFTC_RST_TEMP_PT);
        rd(`DFTC_OFS_CTRL, `DFTC_RST_CTRL);
        chk(4, {4'h0, `DFTC_RST_CPU_PT});
        rd(8'h8F, 8'h00);
        rd(8'h89, 8'h00);
        chk(6, 12'h002);
        // Back-to-back random writes to all five registers, then read back.
        for (i = 0; i < 5; i++) begin
            d[i] = 8'($random(seed));
            wr(`DFTC_OFS_CPU_PT + 8'(i), d[i]);
        end
        for (i = 0; i < 5; i++) rd(`DFTC_OFS_CPU_PT + 8'(i), d[i]);
        chk(5, {9'h000, d[4][7:5]});
        chk(4, {4'h0, d[0]});
        // Locked writes are ignored.
        lock <= 1'b1;
        for (i = 0; i < 5; i++) wr(`DFTC_OFS_CPU_PT + 8'(i), ~d[i]);
        for (i = 0; i < 5; i++) rd(`DFTC_OFS_CPU_PT + 8'(i), d[i]);
        chk(4, {4'h0, d[0]});
        lock <= 1'b0;
        // Every remote2 interval code, its top bit held in control bit 0.
        for (i = 0; i < 8; i++) begin
            wr(`DFTC_OFS_CTRL, {7'h00, i[2]});
            tick(1);
            ivl_low <= i[1:0];
            chk(7, `DFTC_DEC_BASE_CYC << i);
            chk(8, `DFTC_DEC_BASE_CYC << (i + 1));
        end
        // Overtemperature copy: once per rising edge, and despite the lock.
        wr(`DFTC_OFS_CTRL, 8'h1C);
        tick(1);
        ot <= 1'b1;
        for (i = 1; i < 4; i++) d[i] = 8'($random(seed));
        {t1, tl, t2} <= {d[1], d[2], d[3]};
        tick(1);
        chk(1, {4'h0, d[1]});
        chk(2, {4'h0, d[2]});
        chk(3, {4'h0, d[3]});
        t1 <= ~d[1];
        tick(2);
        chk(1, {4'h0, d[1]});
        lock <= 1'b1;
        ot   <= 1'b0;
        tick(1);
        ot <= 1'b1;
        tick(1);
        chk(1, {4'h0, ~d[1]});
        {lock, ot} <= 2'b00;
        // Guarded low core voltage on standby supply.
        wr(`DFTC_OFS_CTRL, 8'hE2);
        tick(1);
        {stby, vlow} <= 2'b11;
        tick(1);
        chk(6, 12'h00D);
        chk(5, 12'h000);
        vlow <= 1'b0;
        tick(1);
        chk(6, 12'h002);
        chk(5, 12'h007);
        // Guard bit clear: low voltage has no effect; copy options clear: overtemp ignored.
        wr(`DFTC_OFS_CTRL, 8'hE0);
        tick(1);
        {vlow, ot} <= 2'b11;
        t1 <= 8'h3C;
        tick(2);
        chk(6, 12'h002);
        chk(5, 12'h007);
        chk(1, {4'h0, ~d[1]});
        tick(1);
        end_of_test();
    end
endmodule
